//--- rtl/ffrs_consts.svh
// Purpose: Register offsets, field positions and reset values of the FIFO read-side block
// Assumes: Included by bare name from the package and the top module
// Notes: Definitions only
`ifndef FFRS_CONSTS_SVH
`define FFRS_CONSTS_SVH

`define FFRS_ADDR_W 8
`define FFRS_BUS_W 32
`define FFRS_STRB_W 4

`define FFRS_OFS_CTRL 8'h00
`define FFRS_OFS_STATUS 8'h04
`define FFRS_OFS_LEVEL 8'h08

`define FFRS_CTRL_LA_BIT 0
`define FFRS_CTRL_RST 1'h0

`define FFRS_ST_EMPTY_BIT 0
`define FFRS_ST_NEAR_EMPTY_BIT 1
`define FFRS_ST_FULL_BIT 2
`define FFRS_ST_NEAR_FULL_BIT 3
`define FFRS_ST_VALID_BIT 4
`define FFRS_ST_LA_BIT 5

`define FFRS_RESP_OKAY 2'h0
`define FFRS_RESP_DECERR 2'h3

`define FFRS_HS_VALID 0
`define FFRS_HS_UNDERFLOW 1
`define FFRS_HS_WR_ACK 2
`define FFRS_HS_OVERFLOW 3
`define FFRS_HS_N 4

`endif

//--- rtl/ffrs_pkg.sv
// Purpose: Types shared by the FIFO read-side block
// Assumes: Constants come from the header
// Notes: Flag groups and bus channels travel as packed structs
`include "ffrs_consts.svh"

package ffrs_pkg;

    typedef struct packed {
        logic wr_ack;
        logic overflow;
        logic full;
        logic near_full;
    } ffrs_wr_flags_t;

    typedef struct packed {
        logic valid;
        logic underflow;
        logic empty;
        logic near_empty;
    } ffrs_rd_flags_t;

    typedef struct packed {
        logic [`FFRS_ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [`FFRS_BUS_W-1:0] wdata;
        logic [`FFRS_STRB_W-1:0] wstrb;
        logic wvalid;
        logic bready;
        logic [`FFRS_ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } ffrs_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [`FFRS_BUS_W-1:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } ffrs_axil_rsp_t;

    typedef enum logic [1:0] {
        FFRS_MODE_STD = 2'h1,
        FFRS_MODE_LA = 2'h2
    } ffrs_mode_t;

    typedef enum logic [1:0] {
        FFRS_WS_COLLECT = 2'h1,
        FFRS_WS_RESP = 2'h2
    } ffrs_wstate_t;

endpackage

//--- rtl/ffrs_mem.sv
// Purpose: Word store of the FIFO with registered read data
// Assumes: One write and one read port on sys_clk
// Notes: Read data change only on a read strobe or reset
`timescale 1ns/10ps
`default_nettype none

module ffrs_mem #(
    parameter int DATA_W = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] store [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= store[rd_addr];
        end
    end
endmodule // ffrs_mem

`default_nettype wire

//--- rtl/ffrs_axil.sv
// Purpose: AXI4-Lite slave front end for the FIFO control registers
// Assumes: One write and one read outstanding at most
// Notes: Address and data may arrive in either order
`include "ffrs_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module ffrs_axil (
    input wire logic sys_clk,
    input wire logic rst,
    input wire ffrs_pkg::ffrs_axil_req_t axil_req,
    output ffrs_pkg::ffrs_axil_rsp_t axil_rsp,
    output logic reg_we,
    output logic [`FFRS_ADDR_W-1:0] reg_waddr,
    output logic [`FFRS_BUS_W-1:0] reg_wdata,
    output logic [`FFRS_STRB_W-1:0] reg_wstrb,
    input wire logic reg_whit,
    output logic [`FFRS_ADDR_W-1:0] reg_raddr,
    input wire logic [`FFRS_BUS_W-1:0] reg_rdata,
    input wire logic reg_rhit
);
    import ffrs_pkg::*;

    ffrs_wstate_t wstate;
    logic aw_held;
    logic w_held;
    logic [1:0] bresp;
    logic [`FFRS_BUS_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic aw_take;
    logic w_take;
    logic ar_take;

    assign aw_take = axil_req.awvalid && !aw_held && (wstate == FFRS_WS_COLLECT);
    assign w_take = axil_req.wvalid && !w_held && (wstate == FFRS_WS_COLLECT);
    assign ar_take = axil_req.arvalid && !rvalid;
    assign reg_we = (wstate == FFRS_WS_COLLECT) && aw_held && w_held;
    assign reg_raddr = axil_req.araddr;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            aw_held <= 1'h0;
            w_held <= 1'h0;
            reg_waddr <= '0;
            reg_wdata <= '0;
            reg_wstrb <= '0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'h1;
                reg_waddr <= axil_req.awaddr;
            end else if (reg_we) begin
                aw_held <= 1'h0;
            end
            if (w_take) begin
                w_held <= 1'h1;
                reg_wdata <= axil_req.wdata;
                reg_wstrb <= axil_req.wstrb;
            end else if (reg_we) begin
                w_held <= 1'h0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wstate <= FFRS_WS_COLLECT;
            bresp <= `FFRS_RESP_OKAY;
        end else begin
            case (wstate)
                FFRS_WS_COLLECT: begin
                    if (reg_we) begin
                        wstate <= FFRS_WS_RESP;
                        bresp <= reg_whit ? `FFRS_RESP_OKAY : `FFRS_RESP_DECERR;
                    end
                end
                FFRS_WS_RESP: begin
                    if (axil_req.bready) begin
                        wstate <= FFRS_WS_COLLECT;
                    end
                end
                default: begin
                    wstate <= FFRS_WS_COLLECT;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rvalid <= 1'h0;
            rdata <= '0;
            rresp <= `FFRS_RESP_OKAY;
        end else if (ar_take) begin
            rvalid <= 1'h1;
            rdata <= reg_rhit ? reg_rdata : '0;
            rresp <= reg_rhit ? `FFRS_RESP_OKAY : `FFRS_RESP_DECERR;
        end else if (axil_req.rready) begin
            rvalid <= 1'h0;
        end
    end

    always_comb begin
        axil_rsp = '0;
        axil_rsp.awready = !aw_held && (wstate == FFRS_WS_COLLECT);
        axil_rsp.wready = !w_held && (wstate == FFRS_WS_COLLECT);
        axil_rsp.bvalid = (wstate == FFRS_WS_RESP);
        axil_rsp.bresp = bresp;
        axil_rsp.arready = !rvalid;
        axil_rsp.rvalid = rvalid;
        axil_rsp.rdata = rdata;
        axil_rsp.rresp = rresp;
    end
endmodule // ffrs_axil

`default_nettype wire

//--- rtl/ffrs_top.sv
// Purpose: Common-clock FIFO with standard and look-ahead read modes and handshake flags
// Assumes: Write and read ports both on sys_clk; control over AXI4-Lite
// Notes: Look-ahead mode keeps two staged words outside the word store
// Function
// - Read with data presents next word, sets valid
// - Empty read ignored, underflow raised
// - Near-empty high with exactly one word left
// - Empty high until written data readable
// - Write plus read while empty: write only
// - Standard data next cycle; look-ahead same cycle
// - Look-ahead: first word falls through unrequested
// - Look-ahead: read past last word invalidates output
// - Standard valid overlaps empty one cycle
// - Look-ahead adds two staged words of depth
// - Look-ahead empty release two cycles later
// - Reads to empty equal accepted writes
// - Steady write plus read keeps flags
// - Handshake flags optional, polarity selectable
// - Write-acknowledge pulses after each stored word
// - Standard valid rises per successful read only
// - Look-ahead valid follows word presence
// - Write while full discarded, overflow raised
// - Refused write keeps write-acknowledge low
// - Refused read raises underflow; valid drops unless look-ahead stage one holds a word
// - Hard-primitive build omits near-empty
// - Each port and flag on its clock
// - Write when not full stores word, acknowledges
`include "ffrs_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module ffrs_top #(
    parameter int DATA_W = 8,
    parameter int DEPTH = 16,
    parameter bit HARD_PRIM = 1'h0,
    parameter bit LOOK_AHEAD_RST = 1'h0,
    parameter logic [`FFRS_HS_N-1:0] HS_EN = 4'hF,
    parameter logic [`FFRS_HS_N-1:0] HS_LOW = 4'h0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire ffrs_pkg::ffrs_axil_req_t axil_req,
    output ffrs_pkg::ffrs_axil_rsp_t axil_rsp,
    input wire logic wr_en,
    input wire logic [DATA_W-1:0] din,
    output ffrs_pkg::ffrs_wr_flags_t wr_flags,
    input wire logic rd_en,
    output logic [DATA_W-1:0] dout,
    output ffrs_pkg::ffrs_rd_flags_t rd_flags
);
    import ffrs_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 3);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_NEAR_FULL = CW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    // Pointer advance with wrap for any depth
    function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] ptr);
        logic [AW-1:0] res;
        res = (ptr == PTR_LAST) ? '0 : AW'(ptr + AW'(1));
        return res;
    endfunction

    ffrs_mode_t mode;
    logic ctrl_la;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] mem_count;
    logic [CW-1:0] total;
    logic [DATA_W-1:0] mem_q;
    logic [DATA_W-1:0] stage_data;
    logic s1_v;
    logic s2_v;
    logic is_la;
    logic full_i;
    logic mem_empty;
    logic wr_ok;
    logic rd_ok_std;
    logic pop;
    logic move12;
    logic fetch;
    logic mem_rd;
    logic next_s1_v;
    logic next_s2_v;
    logic [CW-1:0] next_mem_count;
    logic valid_raw;
    logic underflow_raw;
    logic wr_ack_raw;
    logic overflow_raw;
    logic empty_i;
    logic near_empty_i;
    logic near_full_i;
    logic mode_idle;
    logic [`FFRS_HS_N-1:0] hs_raw;
    logic [`FFRS_HS_N-1:0] hs_pin;

    logic reg_we;
    logic [`FFRS_ADDR_W-1:0] reg_waddr;
    logic [`FFRS_BUS_W-1:0] reg_wdata;
    logic [`FFRS_STRB_W-1:0] reg_wstrb;
    logic reg_whit;
    logic [`FFRS_ADDR_W-1:0] reg_raddr;
    logic [`FFRS_BUS_W-1:0] reg_rdata;
    logic reg_rhit;

    assign is_la = (mode == FFRS_MODE_LA);
    assign full_i = (mem_count == CNT_FULL);
    assign mem_empty = (mem_count == '0);
    assign near_full_i = (mem_count == CNT_NEAR_FULL);

    // Write side acceptance
    assign wr_ok = wr_en && !full_i;

    // Standard read: store holds the word until requested
    assign rd_ok_std = rd_en && !mem_empty;

    // Look-ahead staging: store read register is stage one, stage_data stage two
    assign pop = rd_en && s2_v;
    assign move12 = s1_v && (!s2_v || pop);
    assign fetch = !mem_empty && (!s1_v || move12);
    assign mem_rd = is_la ? fetch : rd_ok_std;

    assign next_s1_v = is_la && (fetch || (s1_v && !move12));
    assign next_s2_v = is_la && (move12 || (s2_v && !pop));

    // Store occupancy; a refused access changes nothing
    always_comb begin
        next_mem_count = mem_count;
        if (wr_ok && !mem_rd) begin
            next_mem_count = CW'(mem_count + CNT_ONE);
        end else if (mem_rd && !wr_ok) begin
            next_mem_count = CW'(mem_count - CNT_ONE);
        end
    end

    // Words held anywhere, staging included
    assign total = CW'(mem_count + CW'(s1_v) + CW'(s2_v));

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr <= '0;
        end else if (wr_ok) begin
            wr_ptr <= ptr_next(wr_ptr);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_ptr <= '0;
        end else if (mem_rd) begin
            rd_ptr <= ptr_next(rd_ptr);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_count <= '0;
        end else begin
            mem_count <= next_mem_count;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s1_v <= 1'h0;
            s2_v <= 1'h0;
        end else begin
            s1_v <= next_s1_v;
            s2_v <= next_s2_v;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stage_data <= '0;
        end else if (move12) begin
            stage_data <= mem_q;
        end
    end

    // Mode switch only while nothing is stored, staged or arriving
    assign mode_idle = (total == '0) && !wr_ok;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode <= LOOK_AHEAD_RST ? FFRS_MODE_LA : FFRS_MODE_STD;
        end else if (mode_idle) begin
            mode <= ctrl_la ? FFRS_MODE_LA : FFRS_MODE_STD;
        end
    end

    ffrs_mem #(
        .DATA_W(DATA_W),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_mem (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_en(wr_ok),
        .wr_addr(wr_ptr),
        .wr_data(din),
        .rd_en(mem_rd),
        .rd_addr(rd_ptr),
        .rd_data(mem_q)
    );

    // Standard valid and underflow registered at the read edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            valid_raw <= 1'h0;
        end else if (is_la) begin
            valid_raw <= next_s2_v;
        end else begin
            valid_raw <= rd_ok_std;
        end
    end

    // Look-ahead refuses a read when the output holds no word
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            underflow_raw <= 1'h0;
        end else if (is_la) begin
            underflow_raw <= rd_en && !s2_v;
        end else begin
            underflow_raw <= rd_en && mem_empty;
        end
    end

    // Write-side pulses last one cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ack_raw <= 1'h0;
            overflow_raw <= 1'h0;
        end else begin
            wr_ack_raw <= wr_ok;
            overflow_raw <= wr_en && full_i;
        end
    end

    // Empty and near-empty straight from shared write state, no crossing
    always_comb begin
        if (is_la) begin
            empty_i = !s2_v;
            near_empty_i = s2_v && (total == CNT_ONE);
        end else begin
            empty_i = mem_empty;
            near_empty_i = (mem_count == CNT_ONE);
        end
    end

    assign hs_raw[`FFRS_HS_VALID] = valid_raw;
    assign hs_raw[`FFRS_HS_UNDERFLOW] = underflow_raw;
    assign hs_raw[`FFRS_HS_WR_ACK] = wr_ack_raw;
    assign hs_raw[`FFRS_HS_OVERFLOW] = overflow_raw;

    // Disabled flags hold their inactive level
    genvar g;
    generate
        for (g = 0; g < `FFRS_HS_N; g++) begin : g_hs
            assign hs_pin[g] = HS_EN[g] ? (hs_raw[g] ^ HS_LOW[g]) : HS_LOW[g];
        end
    endgenerate

    assign dout = is_la ? stage_data : mem_q;

    always_comb begin
        rd_flags.valid = hs_pin[`FFRS_HS_VALID];
        rd_flags.underflow = hs_pin[`FFRS_HS_UNDERFLOW];
        rd_flags.empty = empty_i;
        rd_flags.near_empty = HARD_PRIM ? 1'h0 : near_empty_i;
    end

    always_comb begin
        wr_flags.wr_ack = hs_pin[`FFRS_HS_WR_ACK];
        wr_flags.overflow = hs_pin[`FFRS_HS_OVERFLOW];
        wr_flags.full = full_i;
        wr_flags.near_full = near_full_i;
    end

    // Register file
    ffrs_axil u_axil (
        .sys_clk(sys_clk),
        .rst(rst),
        .axil_req(axil_req),
        .axil_rsp(axil_rsp),
        .reg_we(reg_we),
        .reg_waddr(reg_waddr),
        .reg_wdata(reg_wdata),
        .reg_wstrb(reg_wstrb),
        .reg_whit(reg_whit),
        .reg_raddr(reg_raddr),
        .reg_rdata(reg_rdata),
        .reg_rhit(reg_rhit)
    );

    assign reg_whit = (reg_waddr == `FFRS_OFS_CTRL);

    // Only byte lane zero carries the mode bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_la <= `FFRS_CTRL_RST;
        end else if (reg_we && reg_whit && reg_wstrb[0]) begin
            ctrl_la <= reg_wdata[`FFRS_CTRL_LA_BIT];
        end
    end

    // Unmapped offsets answer with a decode error
    always_comb begin
        reg_rdata = '0;
        reg_rhit = 1'h1;
        case (reg_raddr)
            `FFRS_OFS_CTRL: begin
                reg_rdata[`FFRS_CTRL_LA_BIT] = ctrl_la;
            end
            `FFRS_OFS_STATUS: begin
                reg_rdata[`FFRS_ST_EMPTY_BIT] = empty_i;
                reg_rdata[`FFRS_ST_NEAR_EMPTY_BIT] = near_empty_i && !HARD_PRIM;
                reg_rdata[`FFRS_ST_FULL_BIT] = full_i;
                reg_rdata[`FFRS_ST_NEAR_FULL_BIT] = near_full_i;
                reg_rdata[`FFRS_ST_VALID_BIT] = valid_raw;
                reg_rdata[`FFRS_ST_LA_BIT] = is_la;
            end
            `FFRS_OFS_LEVEL: begin
                reg_rdata[CW-1:0] = total;
            end
            default: begin
                reg_rhit = 1'h0;
            end
        endcase
    end
endmodule // ffrs_top

`default_nettype wire

//--- dv/ffrs_chk.sv
// Purpose: Port-level assertions for the FIFO block
// Assumes: Handshake flags enabled, active high
// Notes: Bound into ffrs_top below
`timescale 1ns/10ps
`default_nettype none

module ffrs_chk #(
    parameter int DATA_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire ffrs_pkg::ffrs_axil_req_t axil_req,
    input wire ffrs_pkg::ffrs_axil_rsp_t axil_rsp,
    input wire logic wr_en,
    input wire logic [DATA_W-1:0] din,
    input wire ffrs_pkg::ffrs_wr_flags_t wr_flags,
    input wire logic rd_en,
    input wire logic [DATA_W-1:0] dout,
    input wire ffrs_pkg::ffrs_rd_flags_t rd_flags
);
    import ffrs_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_wr_ok;
        wr_en && !wr_flags.full;
    endsequence
    sequence s_wr_into_empty;
        s_wr_ok ##0 rd_flags.empty;
    endsequence

    chk_wr_acked: assert property (
        s_wr_ok |=> wr_flags.wr_ack && !wr_flags.overflow)
        else $error("accepted write not acknowledged");
    chk_ovf_refused: assert property (
        wr_en && wr_flags.full |=> wr_flags.overflow && !wr_flags.wr_ack)
        else $error("refused write not flagged");
    chk_ack_cause: assert property (
        wr_flags.wr_ack |-> $past(wr_en) && !$past(wr_flags.full))
        else $error("acknowledge without accepted write");
    chk_uf_refused: assert property (
        rd_en && rd_flags.empty |=> rd_flags.underflow && !rd_flags.valid)
        else $error("refused read not flagged");
    chk_rd_no_uf: assert property (
        rd_en && !rd_flags.empty |=> !rd_flags.underflow)
        else $error("underflow on a read with data");
    chk_empty_hold: assert property (
        rd_flags.empty && !wr_en && !$past(wr_en) && !$past(wr_en, 2) |=> rd_flags.empty)
        else $error("empty dropped without a write");
    chk_empty_release: assert property (
        s_wr_into_empty |=> ##[0:2] !rd_flags.empty)
        else $error("empty not released after write");
    chk_near_empty: assert property (
        rd_flags.near_empty |-> !rd_flags.empty)
        else $error("near-empty together with empty");
    chk_steady_flags: assert property (
        wr_en && rd_en && !rd_flags.empty && !rd_flags.near_empty && !wr_flags.full
        |=> $stable({rd_flags.empty, rd_flags.near_empty})
        && $stable({wr_flags.full, wr_flags.near_full}))
        else $error("flags moved on write plus read");
    chk_read_resp: assert property (
        axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
        else $error("read response late");
    chk_write_resp: assert property (
        axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
        |=> ##1 axil_rsp.bvalid)
        else $error("write response late");
endmodule // ffrs_chk

bind ffrs_top ffrs_chk #(.DATA_W(DATA_W)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .axil_req(axil_req), .axil_rsp(axil_rsp),
    .wr_en(wr_en), .din(din), .wr_flags(wr_flags),
    .rd_en(rd_en), .dout(dout), .rd_flags(rd_flags)
);

`default_nettype wire

//--- dv/ffrs_user.sv
// Purpose: User logic model on the FIFO write and read ports
// Assumes: Bench calls step once per request cycle
// Notes: Idle data lines show a changing pattern
`timescale 1ns/10ps
`default_nettype none

module ffrs_user (
    input wire logic sys_clk,
    output logic wr_en,
    output logic [7:0] din,
    output logic rd_en
);
    initial begin
        wr_en = 1'h0;
        rd_en = 1'h0;
        din = 8'h00;
    end

    // Requests held until the next rising edge samples them
    task automatic step(input logic w, input logic [7:0] d, input logic r);
        wr_en <= w;
        din <= w ? d : ~din;
        rd_en <= r;
        @(posedge sys_clk);
        #1;
    endtask
endmodule // ffrs_user

`default_nettype wire

//--- dv/ffrs_top_tb.sv
// Purpose: Self-checking bench for the FIFO block
// Assumes: Common clock, small store depth
// Notes: Scenarios run in standard mode, then look-ahead
`include "ffrs_consts.svh"
`timescale 1ns/10ps
`default_nettype none
`define FFRS_CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end

module ffrs_top_tb;
    import ffrs_pkg::*;
    localparam int DEPTH = 8;
    localparam logic [31:0] LA_EMPTY = (32'h1 << `FFRS_ST_EMPTY_BIT) | (32'h1 << `FFRS_ST_LA_BIT);
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    ffrs_axil_req_t axil_req = '0;
    ffrs_axil_rsp_t axil_rsp;
    logic wr_en;
    logic rd_en;
    logic [7:0] din;
    logic [7:0] dout;
    ffrs_wr_flags_t wr_flags;
    ffrs_rd_flags_t rd_flags;
    int err_count = 0;
    int check_count = 0;

    always #4 sys_clk = ~sys_clk;

    ffrs_user u_user (.sys_clk(sys_clk), .wr_en(wr_en), .din(din), .rd_en(rd_en));

    ffrs_top #(.DEPTH(DEPTH)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .axil_req(axil_req), .axil_rsp(axil_rsp),
        .wr_en(wr_en), .din(din), .wr_flags(wr_flags),
        .rd_en(rd_en), .dout(dout), .rd_flags(rd_flags)
    );

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        axil_req.awaddr <= a;
        axil_req.wdata <= d;
        axil_req.wstrb <= 4'hF;
        axil_req.awvalid <= 1'h1;
        axil_req.wvalid <= 1'h1;
        axil_req.bready <= 1'h1;
        do begin
            @(posedge sys_clk);
            n++;
            if (axil_req.awvalid && axil_rsp.awready) axil_req.awvalid <= 1'h0;
            if (axil_req.wvalid && axil_rsp.wready) axil_req.wvalid <= 1'h0;
        end while (!axil_rsp.bvalid && n < 40);
        axil_req.bready <= 1'h0;
        if (!axil_rsp.bvalid) begin
            err_count++;
            finish_test();
        end
        `FFRS_CHK(axil_rsp.bresp, er);
        // One edge between calls so bready never re-rises in the same step
        @(posedge sys_clk);
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        axil_req.araddr <= a;
        axil_req.arvalid <= 1'h1;
        axil_req.rready <= 1'h1;
        do begin
            @(posedge sys_clk);
            n++;
            if (axil_req.arvalid && axil_rsp.arready) axil_req.arvalid <= 1'h0;
        end while (!axil_rsp.rvalid && n < 40);
        axil_req.rready <= 1'h0;
        if (!axil_rsp.rvalid) begin
            err_count++;
            finish_test();
        end
        `FFRS_CHK(axil_rsp.rdata, ed);
        `FFRS_CHK(axil_rsp.rresp, er);
        // One edge between calls so rready never re-rises in the same step
        @(posedge sys_clk);
    endtask

    task automatic t_regs();
        axi_read(`FFRS_OFS_STATUS, 32'h1 << `FFRS_ST_EMPTY_BIT, `FFRS_RESP_OKAY);
        axi_read(8'h0C, 32'h0, `FFRS_RESP_DECERR);
        axi_write(8'h0C, 32'h1, `FFRS_RESP_DECERR);
        axi_read(`FFRS_OFS_CTRL, 32'h0, `FFRS_RESP_OKAY);
        axi_read(`FFRS_OFS_LEVEL, 32'h0, `FFRS_RESP_OKAY);
    endtask

    task automatic t_std();
        u_user.step(1'h1, 8'hA1, 1'h1);
        `FFRS_CHK(wr_flags, 4'h8);
        `FFRS_CHK(rd_flags, 4'h5);
        u_user.step(1'h1, 8'hA2, 1'h1);
        `FFRS_CHK(rd_flags, 4'h9);
        `FFRS_CHK(dout, 8'hA1);
        u_user.step(1'h0, 8'h00, 1'h1);
        `FFRS_CHK(rd_flags, 4'hA);
        `FFRS_CHK(dout, 8'hA2);
        u_user.step(1'h0, 8'h00, 1'h1);
        `FFRS_CHK(rd_flags, 4'h6);
        `FFRS_CHK(dout, 8'hA2);
        u_user.step(1'h0, 8'h00, 1'h0);
        `FFRS_CHK(rd_flags, 4'h2);
    endtask

    task automatic t_steady();
        u_user.step(1'h1, 8'hB1, 1'h0);
        u_user.step(1'h1, 8'hB2, 1'h0);
        u_user.step(1'h1, 8'hB3, 1'h1);
        `FFRS_CHK(rd_flags, 4'h8);
        `FFRS_CHK(wr_flags, 4'h8);
        `FFRS_CHK(dout, 8'hB1);
        u_user.step(1'h0, 8'h00, 1'h1);
        `FFRS_CHK(rd_flags, 4'h9);
        `FFRS_CHK(dout, 8'hB2);
        u_user.step(1'h0, 8'h00, 1'h1);
        `FFRS_CHK(rd_flags, 4'hA);
        `FFRS_CHK(dout, 8'hB3);
        u_user.step(1'h0, 8'h00, 1'h0);
    endtask

    task automatic t_full();
        for (int i = 0; i < DEPTH; i++) begin
            u_user.step(1'h1, 8'(i + 16), 1'h0);
            `FFRS_CHK(wr_flags.wr_ack, 1'h1);
            `FFRS_CHK(wr_flags[1:0], {1'(i == DEPTH - 1), 1'(i == DEPTH - 2)});
        end
        u_user.step(1'h1, 8'hEE, 1'h0);
        `FFRS_CHK(wr_flags, 4'h6);
        for (int i = 0; i < DEPTH; i++) begin
            u_user.step(1'h0, 8'h00, 1'h1);
            `FFRS_CHK(dout, 8'(i + 16));
            `FFRS_CHK(rd_flags.valid, 1'h1);
        end
        `FFRS_CHK(rd_flags.empty, 1'h1);
        u_user.step(1'h0, 8'h00, 1'h0);
    endtask

    task automatic t_la();
        axi_write(`FFRS_OFS_CTRL, 32'h1, `FFRS_RESP_OKAY);
        axi_read(`FFRS_OFS_STATUS, LA_EMPTY, `FFRS_RESP_OKAY);
        u_user.step(1'h1, 8'h40, 1'h0);
        `FFRS_CHK(rd_flags.empty, 1'h1);
        u_user.step(1'h0, 8'h00, 1'h0);
        `FFRS_CHK(rd_flags.empty, 1'h1);
        u_user.step(1'h0, 8'h00, 1'h0);
        `FFRS_CHK(rd_flags, 4'h9);
        `FFRS_CHK(dout, 8'h40);
        for (int i = 1; i < DEPTH + 2; i++) begin
            u_user.step(1'h1, 8'(8'h40 + i), 1'h0);
            `FFRS_CHK(wr_flags.wr_ack, 1'h1);
        end
        u_user.step(1'h1, 8'hEE, 1'h0);
        `FFRS_CHK(wr_flags.overflow, 1'h1);
        axi_read(`FFRS_OFS_LEVEL, 32'(DEPTH + 2), `FFRS_RESP_OKAY);
        for (int i = 0; i < DEPTH + 2; i++) begin
            `FFRS_CHK(rd_flags.valid, 1'h1);
            `FFRS_CHK(rd_flags.near_empty, 1'(i == DEPTH + 1));
            `FFRS_CHK(dout, 8'(8'h40 + i));
            u_user.step(1'h0, 8'h00, 1'h1);
        end
        `FFRS_CHK(rd_flags, 4'h2);
        u_user.step(1'h0, 8'h00, 1'h1);
        `FFRS_CHK(rd_flags, 4'h6);
        u_user.step(1'h0, 8'h00, 1'h0);
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'h0;
        @(posedge sys_clk);
        t_regs();
        t_std();
        t_steady();
        t_full();
        t_la();
        finish_test();
    end
endmodule // ffrs_top_tb

`default_nettype wire
